// ==== rtl/pscl_core.sv ====
// pscl_core: delay after bus return, pir sensitivity and interlock, brightness reporting
// assumes sensor strobes come from logic on ref_clk; adjuster and remote pins are async
// Contract
// - hold auto-sends for delay after bus return
// - no delay after commissioning restart
// - low basic sensitivity reduces all sectors; here only basic_low is raised, sector_level stays as set
// - unsupported basic setting forces high
// - per sector off/25/50/75/100 percent
// - adjuster shifts every sector that is not off one level, held within 25..100 percent
// - matching interlock telegram locks, retriggers
// - lockout 0..59 s, default 3
// - two-byte brightness, four send modes
// - send on change by lux step
// - cyclic send after minutes plus seconds
// - factory calibration coefficient 0.3
// - reference telegram sets coefficient
// - no evaluation until calibrated
// - pending calibration sends zero or 7fff; zero is held back here, only 7fff with marker is sent
// - walking test after download, blue led
// - remote toggles walking test anytime
//
// The register addresses and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/1ns
module pscl_core (
    // clock and reset
    input  wire logic                     ref_clk,
    input  wire logic                     resetn,
    // register bus
    input  wire pscl_pkg::pscl_avreq_type av_req,
    output      pscl_pkg::pscl_avrsp_type av_rsp,
    // restart causes, one-cycle pulses
    input  wire logic                     bus_return,
    input  wire logic                     download_done,
    // interlock telegram
    input  wire logic                     interlock_valid,
    input  wire logic                     interlock_value,
    // pir raw motion per sector a..c
    input  wire logic [2:0]               pir_raw,
    // async pins: adjuster and remote walking test
    input  wire logic                     adj_up_pin,
    input  wire logic                     adj_down_pin,
    input  wire logic                     ir_test_on_pin,
    input  wire logic                     ir_test_off_pin,
    // brightness sample
    input  wire logic                     light_valid,
    input  wire logic [15:0]              light_guide,
    // outputs
    output      logic [8:0]               sector_level,
    output      logic                     basic_low,
    output      logic                     motion,
    output      logic                     blue_led,
    output      logic                     bright_send,
    output      logic [15:0]              bright_value,
    output      logic                     fb_enable
);
    typedef struct packed {
        logic [11:0] pins;        // 3 stages of 4 pins
        logic [3:0]  pin_state;
        logic [24:0] tick_cnt;
        logic [5:0]  dly_min, dly_sec, lock_sec, step, cyc_min, cyc_sec;
        logic [1:0]  txmode, ilpol;
        logic        basic_lo_cfg, adj_en, cal_tg, inv_mark, walk_cfg;
        logic [8:0]  sens_cfg;
        logic [11:0] hold_cnt;
        logic        holding;
        logic [5:0]  lock_cnt;
        logic [11:0] cyc_cnt;
        logic [15:0] coef, raw, work, last_sent;
        logic        calibrated, walk, pend_send;
        logic [1:0]  adj_ofs;     // 0 none, 1 up, 2 down
        logic [15:0] out_val;
        logic        send, motion_q, rd_phase;
        logic [31:0] rdata;
    } pscl_state_type;

    pscl_state_type st, next_st;
    logic           tick;
    logic [31:0]    product;
    logic [15:0]    delta;
    logic [11:0]    total_cyc;

    assign tick = (st.tick_cnt == pscl_pkg::TICK_LAST);
    assign product = 32'(st.raw) * 32'(st.coef);
    assign delta = (st.work > st.last_sent) ? st.work - st.last_sent : st.last_sent - st.work;
    assign total_cyc = 12'(st.cyc_min) * 12'd60 + 12'(st.cyc_sec);

    // per-sector effective level, adjuster applied
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_sect
            logic [2:0] cfg_lvl;
            assign cfg_lvl = st.sens_cfg[3*g +: 3];
            always_comb begin
                sector_level[3*g +: 3] = cfg_lvl;
                if (st.adj_en && cfg_lvl != 3'h0) begin
                    if (st.adj_ofs == 2'h1 && cfg_lvl < pscl_pkg::SENS_MAX)
                        sector_level[3*g +: 3] = cfg_lvl + 3'h1;
                    else if (st.adj_ofs == 2'h2 && cfg_lvl > 3'h1)
                        sector_level[3*g +: 3] = cfg_lvl - 3'h1;
                end
            end
        end
    endgenerate

    // next-state logic
    always_comb begin
        logic [3:0] agreed;
        agreed = '0;
        next_st = st;
        next_st.send = 1'b0;
        next_st.rd_phase = 1'b0;
        // pin synchroniser: change counts once stages 2 and 3 agree
        next_st.pins = {st.pins[7:0], adj_up_pin, adj_down_pin, ir_test_on_pin,
                        ir_test_off_pin};
        for (int i = 0; i < 4; i++) begin
            agreed[i] = (st.pins[4+i] == st.pins[8+i]) ? st.pins[4+i] : st.pin_state[i];
        end
        next_st.pin_state = agreed;
        next_st.adj_ofs = agreed[3] ? 2'h1 : (agreed[2] ? 2'h2 : 2'h0);
        if (agreed[1] && !st.pin_state[1])
            next_st.walk = 1'b1;
        if (agreed[0] && !st.pin_state[0])
            next_st.walk = 1'b0;
        // seconds tick
        next_st.tick_cnt = tick ? 25'h0 : st.tick_cnt + 25'h1;
        // transmit hold after bus return
        if (st.holding && tick) begin
            if (st.hold_cnt <= 12'h1)
                next_st.holding = 1'b0;
            next_st.hold_cnt = st.hold_cnt - 12'h1;
        end
        if (bus_return) begin
            next_st.hold_cnt = 12'(st.dly_min) * 12'd60 + 12'(st.dly_sec);
            next_st.holding = (st.dly_min != 6'h0) || (st.dly_sec != 6'h0);
        end
        if (download_done) begin
            next_st.holding = 1'b0;
            next_st.pend_send = 1'b1;
            if (st.walk_cfg)
                next_st.walk = 1'b1;
        end
        // interlock lockout, restarts on each matching telegram
        if (st.lock_cnt != 6'h0 && tick)
            next_st.lock_cnt = st.lock_cnt - 6'h1;
        if (interlock_valid &&
            ((st.ilpol == 2'(pscl_pkg::IL_OFF) && !interlock_value) ||
             (st.ilpol == 2'(pscl_pkg::IL_ON) && interlock_value) ||
             st.ilpol == 2'(pscl_pkg::IL_BOTH)))
            next_st.lock_cnt = st.lock_sec;
        next_st.motion_q = (|pir_raw) && (next_st.lock_cnt == 6'h0) && !(interlock_valid &&
                           next_st.lock_cnt != st.lock_cnt);
        // brightness
        if (light_valid)
            next_st.raw = light_guide;
        next_st.work = product[27:12] > 32'h7ffe ? 16'h7ffe : product[27:12];
        if (!st.calibrated && st.cal_tg)
            next_st.out_val = st.inv_mark ? pscl_pkg::INVALID_BRIGHT : 16'h0;
        else
            next_st.out_val = st.work;
        // cyclic timer
        if (tick) begin
            if (st.cyc_cnt <= 12'h1) begin
                next_st.cyc_cnt = total_cyc;
                if (st.txmode == 2'(pscl_pkg::TX_CYCLIC) || st.txmode == 2'(pscl_pkg::TX_BOTH))
                    next_st.pend_send = 1'b1;
            end else
                next_st.cyc_cnt = st.cyc_cnt - 12'h1;
        end
        if ((st.txmode == 2'(pscl_pkg::TX_ON_CHANGE) || st.txmode == 2'(pscl_pkg::TX_BOTH)) &&
            delta >= 16'(st.step) * 16'(pscl_pkg::STEP_LUX) && (st.calibrated || !st.cal_tg))
            next_st.pend_send = 1'b1;
        if (st.pend_send && !st.holding && !(st.cal_tg && !st.calibrated && !st.inv_mark)) begin
            next_st.send = 1'b1;
            next_st.pend_send = 1'b0;
            next_st.last_sent = st.work;
        end
        if (st.txmode == 2'(pscl_pkg::TX_ON_READ))
            next_st.pend_send = 1'b0;
        // register bus: one wait state for reads, writes take at once
        next_st.rdata = st.rdata;
        if (av_req.read && !st.rd_phase) begin
            next_st.rd_phase = 1'b1;
            unique case (av_req.address)
                pscl_pkg::REG_CTRL:   next_st.rdata = {22'h0, st.walk_cfg, st.inv_mark, st.cal_tg,
                                       st.ilpol, st.adj_en, st.basic_lo_cfg, st.txmode, 1'b0};
                pscl_pkg::REG_DELAY:  next_st.rdata = {20'h0, st.dly_min, st.dly_sec};
                pscl_pkg::REG_SENS:   next_st.rdata = {23'h0, st.sens_cfg};
                pscl_pkg::REG_LOCK:   next_st.rdata = {26'h0, st.lock_sec};
                pscl_pkg::REG_BRIGHT: next_st.rdata = {26'h0, st.step};
                pscl_pkg::REG_CYCLE:  next_st.rdata = {20'h0, st.cyc_min, st.cyc_sec};
                pscl_pkg::REG_RAW:    next_st.rdata = {16'h0, st.raw};
                pscl_pkg::REG_CALREF: next_st.rdata = {16'h0, st.coef};
                pscl_pkg::REG_STATUS: next_st.rdata = {20'h0, st.lock_cnt, st.walk,
                                       st.calibrated, st.holding, st.motion_q, basic_low,
                                       st.pend_send};
                pscl_pkg::REG_OUTVAL: next_st.rdata = {16'h0, st.out_val};
                default:              next_st.rdata = 32'h0;
            endcase
        end
        if (av_req.write) begin
            unique case (av_req.address)
                pscl_pkg::REG_CTRL: begin
                    next_st.txmode = av_req.writedata[2:1];
                    next_st.basic_lo_cfg = av_req.writedata[3];
                    next_st.adj_en = av_req.writedata[4];
                    next_st.ilpol = av_req.writedata[6:5] == 2'h3 ? 2'h0 : av_req.writedata[6:5];
                    if (av_req.writedata[7] && !st.cal_tg)
                        next_st.calibrated = 1'b0;
                    if (!av_req.writedata[7])
                        next_st.coef = pscl_pkg::FACT_COEF;
                    next_st.cal_tg = av_req.writedata[7];
                    next_st.inv_mark = av_req.writedata[8];
                    next_st.walk_cfg = av_req.writedata[9];
                end
                pscl_pkg::REG_DELAY: begin
                    if (av_req.writedata[5:0] < 6'd60) next_st.dly_sec = av_req.writedata[5:0];
                    if (av_req.writedata[11:6] < 6'd60) next_st.dly_min = av_req.writedata[11:6];
                end
                pscl_pkg::REG_SENS:
                    for (int s = 0; s < 3; s++)
                        if (av_req.writedata[3*s +: 3] <= pscl_pkg::SENS_MAX)
                            next_st.sens_cfg[3*s +: 3] = av_req.writedata[3*s +: 3];
                pscl_pkg::REG_LOCK:
                    if (av_req.writedata[5:0] < 6'd60) next_st.lock_sec = av_req.writedata[5:0];
                pscl_pkg::REG_BRIGHT:
                    if (av_req.writedata[5:0] >= pscl_pkg::STEP_MIN &&
                        av_req.writedata[5:0] <= pscl_pkg::STEP_MAX)
                        next_st.step = av_req.writedata[5:0];
                pscl_pkg::REG_CYCLE: begin
                    if (av_req.writedata[5:0] < 6'd60) next_st.cyc_sec = av_req.writedata[5:0];
                    if (av_req.writedata[11:6] < 6'd60) next_st.cyc_min = av_req.writedata[11:6];
                end
                pscl_pkg::REG_CALREF:
                    if (st.cal_tg && st.raw != 16'h0) begin
                        // coefficient = ref / raw in q4.12
                        next_st.coef = 16'((32'(av_req.writedata[15:0]) << 12) / 32'(st.raw));
                        next_st.calibrated = 1'b1;
                    end
                pscl_pkg::REG_EVENT:
                    if (av_req.writedata[0]) next_st.pend_send = 1'b1; // read request answer
                default: ;
            endcase
        end
    end

    // state register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
            st.dly_min <= pscl_pkg::DELAY_MIN_RST;
            st.dly_sec <= pscl_pkg::DELAY_SEC_RST;
            st.sens_cfg <= {3{pscl_pkg::SECT_SENS_RST}};
            st.lock_sec <= pscl_pkg::LOCK_SEC_RST;
            st.step <= pscl_pkg::STEP_RST;
            st.cyc_min <= pscl_pkg::CYC_MIN_RST;
            st.cyc_sec <= pscl_pkg::CYC_SEC_RST;
            st.coef <= pscl_pkg::FACT_COEF;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign basic_low = st.basic_lo_cfg && pscl_pkg::BASIC_SUPPORT;
    assign motion = st.motion_q;
    assign blue_led = st.walk && st.motion_q;
    assign bright_send = st.send;
    assign bright_value = st.out_val;
    assign fb_enable = st.calibrated || !st.cal_tg;
    assign av_rsp.readdata = st.rdata;
    assign av_rsp.waitrequest = av_req.read && !st.rd_phase;
endmodule // pscl_core

// ==== rtl/pscl_pkg.sv ====
// pscl_pkg: constants, types and register map of the presence sensor config logic
// assumes a 20 MHz reference clock and a 32-bit Avalon-MM register slave
package pscl_pkg;
    // clock and tick
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned TICK_PERIOD_S   = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_PERIOD_S;
    localparam logic [24:0] TICK_LAST       = 25'(TICK_CYCLES - 1);
    // word offsets (byte address = 4 * index)
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_DELAY    = 4'h1;
    localparam logic [3:0] REG_SENS     = 4'h2;
    localparam logic [3:0] REG_LOCK     = 4'h3;
    localparam logic [3:0] REG_BRIGHT   = 4'h4;
    localparam logic [3:0] REG_CYCLE    = 4'h5;
    localparam logic [3:0] REG_RAW      = 4'h6;
    localparam logic [3:0] REG_CALREF   = 4'h7;
    localparam logic [3:0] REG_STATUS   = 4'h8;
    localparam logic [3:0] REG_OUTVAL   = 4'h9;
    localparam logic [3:0] REG_EVENT    = 4'ha;
    // reset values
    localparam logic [5:0]  DELAY_MIN_RST   = 6'h00;
    localparam logic [5:0]  DELAY_SEC_RST   = 6'h11; // 17 s
    localparam logic [2:0]  SECT_SENS_RST   = 3'h4;  // 100 %
    localparam logic [5:0]  LOCK_SEC_RST    = 6'h03;
    localparam logic [5:0]  STEP_RST        = 6'h04; // 4 * 5 lux = 20 lux
    localparam logic [5:0]  CYC_MIN_RST     = 6'h03;
    localparam logic [5:0]  CYC_SEC_RST     = 6'h00;
    localparam logic [15:0] INVALID_BRIGHT  = 16'h7fff;
    localparam logic [15:0] FACT_COEF       = 16'h04cd; // 0.3 in q4.12
    localparam logic [15:0] UNIT_COEF       = 16'h1000;
    localparam logic [5:0]  STEP_MIN        = 6'h01;
    localparam logic [5:0]  STEP_MAX        = 6'h28;
    localparam logic [7:0]  STEP_LUX        = 8'h05;
    localparam logic [2:0]  SENS_MAX        = 3'h4;
    // hardware/application support for basic sensitivity, arbitrary default
    localparam logic        BASIC_SUPPORT   = 1'b1;

    typedef enum logic [1:0] {
        TX_ON_CHANGE,
        TX_CYCLIC,
        TX_BOTH,
        TX_ON_READ
    } pscl_txmode_type;

    typedef enum logic [1:0] {
        IL_OFF,
        IL_ON,
        IL_BOTH,
        IL_RSVD
    } pscl_ilpol_type;

    // avalon request / answer
    typedef struct packed {
        logic [3:0]  address;
        logic        read;
        logic        write;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } pscl_avreq_type;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } pscl_avrsp_type;
endpackage

// ==== verif/presence_sensor_config_logic_tb.sv ====
// presence_sensor_config_logic_tb: register, sensitivity, interlock, walk, brightness
// assumes pscl_core, its checker and the bus party model are compiled alongside
`timescale 1ns/1ns
module presence_sensor_config_logic_tb;
    logic                     ref_clk = 1'b0;
    logic                     resetn = 1'b0;
    pscl_pkg::pscl_avreq_type av_req = '0;
    pscl_pkg::pscl_avrsp_type av_rsp;
    logic                     bus_return = 1'b0;
    logic                     download_done = 1'b0;
    logic [2:0]               pir_raw = 3'h0;
    logic                     adj_up_pin = 1'b0;
    logic                     adj_down_pin = 1'b0;
    logic                     ir_test_on_pin = 1'b0;
    logic                     ir_test_off_pin = 1'b0;
    logic                     interlock_valid, interlock_value, light_valid, fb_enable;
    logic                     basic_low, motion, blue_led, bright_send;
    logic [15:0]              light_guide, bright_value;
    logic [8:0]               sector_level;
    int                       err_count = 0;
    int                       check_count = 0;
    int                       n0;
    always #25 ref_clk = ~ref_clk;
    pscl_core i_dut (.ref_clk, .resetn, .av_req, .av_rsp, .bus_return, .download_done,
        .interlock_valid, .interlock_value, .pir_raw, .adj_up_pin, .adj_down_pin,
        .ir_test_on_pin, .ir_test_off_pin, .light_valid, .light_guide, .sector_level,
        .basic_low, .motion, .blue_led, .bright_send, .bright_value, .fb_enable);
    pscl_bus_party i_party (.ref_clk, .interlock_valid, .interlock_value, .light_valid,
        .light_guide, .bright_send, .bright_value);
    task automatic results();
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one transfer, held until waitrequest is seen low
    task automatic bus(input logic [3:0] a, input logic r, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        av_req <= '{address: a, read: r, write: !r, writedata: d, byteenable: 4'hf};
        do begin
            @(posedge ref_clk);
            n++;
        end while (av_rsp.waitrequest !== 1'b0 && n < 50);
        if (n >= 50) begin
            err_count++;
            results();
        end
        q = av_rsp.readdata;
        av_req <= '0;
        @(posedge ref_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(a, 1'b0, d, q);
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [31:0] m,
                      input logic [31:0] exp);
        logic [31:0] q;
        bus(a, 1'b1, 32'h0, q);
        chk(what, exp, q & m);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // restart cause pulse: download when dl, else bus return
    task automatic restart(input logic dl);
        download_done <= dl;
        bus_return <= !dl;
        @(posedge ref_clk);
        download_done <= 1'b0;
        bus_return <= 1'b0;
        idle(4);
    endtask
    // watchdog
    initial begin
        repeat (90000) @(posedge ref_clk);
        err_count++;
        results();
    end
    // main sequence
    initial begin
        idle(4);
        resetn <= 1'b1;
        idle(1);
        rd("delay", pscl_pkg::REG_DELAY, 32'hfff, 32'h011);
        rd("sens", pscl_pkg::REG_SENS, 32'h1ff, 32'h124);
        rd("lock", pscl_pkg::REG_LOCK, 32'h3f, 32'h003);
        rd("step", pscl_pkg::REG_BRIGHT, 32'h3f, 32'h004);
        rd("cycle", pscl_pkg::REG_CYCLE, 32'hfff, 32'h0c0);
        rd("unmapped", 4'hf, 32'hffffffff, 32'h0);
        chk("level", 32'h124, 32'(sector_level));
        // sector levels and adjuster up, down and disabled
        wr(pscl_pkg::REG_SENS, 32'h0d1);
        wr(pscl_pkg::REG_CTRL, 32'h010);
        chk("level", 32'h0d1, 32'(sector_level));
        adj_up_pin <= 1'b1;
        idle(8);
        chk("adj up", 32'h11a, 32'(sector_level));
        adj_up_pin <= 1'b0;
        adj_down_pin <= 1'b1;
        idle(8);
        chk("adj down", 32'h089, 32'(sector_level));
        adj_down_pin <= 1'b0;
        wr(pscl_pkg::REG_CTRL, 32'h008);
        adj_up_pin <= 1'b1;
        idle(8);
        chk("adj off", 32'h0d1, 32'(sector_level));
        chk("basic", 32'h1, 32'(basic_low));
        adj_up_pin <= 1'b0;
        wr(pscl_pkg::REG_SENS, 32'h124);
        chk("low level", 32'h124, 32'(sector_level));
        // interlock polarity on: off telegram ignored, on telegram locks
        wr(pscl_pkg::REG_CTRL, 32'h020);
        pir_raw <= 3'h7;
        idle(6);
        chk("motion", 32'h1, 32'(motion));
        i_party.telegram(1'b0);
        idle(4);
        chk("no lock", 32'h1, 32'(motion));
        i_party.telegram(1'b1);
        idle(4);
        chk("locked", 32'h0, 32'(motion));
        rd("lock cnt", pscl_pkg::REG_STATUS, 32'hfc0, 32'h0c0);
        // reset in mid-run clears the lockout
        resetn <= 1'b0;
        idle(2);
        resetn <= 1'b1;
        idle(6);
        chk("motion", 32'h1, 32'(motion));
        // walking test after download and by remote
        wr(pscl_pkg::REG_CTRL, 32'h200);
        restart(1'b1);
        chk("walk led", 32'h1, 32'(blue_led));
        ir_test_off_pin <= 1'b1;
        idle(8);
        ir_test_off_pin <= 1'b0;
        idle(2);
        chk("walk off", 32'h0, 32'(blue_led));
        ir_test_on_pin <= 1'b1;
        idle(8);
        ir_test_on_pin <= 1'b0;
        idle(2);
        chk("walk on", 32'h1, 32'(blue_led));
        pir_raw <= 3'h0;
        // factory calibration, send on read request
        wr(pscl_pkg::REG_CTRL, 32'h006);
        i_party.light(16'h1000);
        n0 = i_party.sent;
        wr(pscl_pkg::REG_EVENT, 32'h1);
        idle(4);
        chk("read send", 32'(n0 + 1), 32'(i_party.sent));
        chk("factory", 32'h04cd, 32'(i_party.last));
        // on change and cyclic: 4 lux ignored, 24 lux sent
        wr(pscl_pkg::REG_CTRL, 32'h004);
        n0 = i_party.sent;
        i_party.light(16'h1010);
        idle(4);
        chk("small", 32'(n0), 32'(i_party.sent));
        i_party.light(16'h1050);
        idle(4);
        chk("step send", 32'(n0 + 1), 32'(i_party.sent));
        chk("step val", 32'h04e5, 32'(i_party.last));
        // bus return holds sends, a download lifts the hold
        n0 = i_party.sent;
        restart(1'b0);
        rd("holding", pscl_pkg::REG_STATUS, 32'h8, 32'h8);
        i_party.light(16'h1100);
        idle(20);
        chk("held", 32'(n0), 32'(i_party.sent));
        restart(1'b1);
        rd("released", pscl_pkg::REG_STATUS, 32'h8, 32'h0);
        chk("dl send", 32'(n0 + 1), 32'(i_party.sent));
        wr(pscl_pkg::REG_DELAY, 32'h000);
        restart(1'b0);
        rd("zero delay", pscl_pkg::REG_STATUS, 32'h8, 32'h0);
        // telegram calibration pending with invalid marker, then reference
        i_party.light(16'h1000);
        wr(pscl_pkg::REG_CTRL, 32'h186);
        chk("fb off", 32'h0, 32'(fb_enable));
        rd("outval", pscl_pkg::REG_OUTVAL, 32'hffff, 32'h7fff);
        n0 = i_party.sent;
        wr(pscl_pkg::REG_EVENT, 32'h1);
        idle(4);
        chk("marker n", 32'(n0 + 1), 32'(i_party.sent));
        chk("marker", 32'h7fff, 32'(i_party.last));
        wr(pscl_pkg::REG_CALREF, 32'h1f4);
        idle(2);
        chk("fb on", 32'h1, 32'(fb_enable));
        wr(pscl_pkg::REG_EVENT, 32'h1);
        idle(4);
        chk("cal val", 32'h01f4, 32'(i_party.last));
        results();
    end
endmodule // presence_sensor_config_logic_tb

// ==== verif/pscl_bus_party.sv ====
// pscl_bus_party: other bus subscribers; interlock telegrams, light samples, send log
// assumes tasks are called just after a rising edge of ref_clk
`timescale 1ns/1ns
module pscl_bus_party (
    // clock
    input  wire logic        ref_clk,
    // towards the core
    output      logic        interlock_valid,
    output      logic        interlock_value,
    output      logic        light_valid,
    output      logic [15:0] light_guide,
    // from the core
    input  wire logic        bright_send,
    input  wire logic [15:0] bright_value
);
    int          sent = 0;
    logic [15:0] last = 16'h0000;
    initial begin
        interlock_valid = 1'b0;
        interlock_value = 1'b1;
        light_valid = 1'b0;
        light_guide = 16'hffff;
    end
    // one 1-bit telegram; the line shows the inverse once released
    task automatic telegram(input logic v);
        interlock_valid <= 1'b1;
        interlock_value <= v;
        @(posedge ref_clk);
        interlock_valid <= 1'b0;
        interlock_value <= ~v;
        @(posedge ref_clk);
    endtask
    // one light-guide sample
    task automatic light(input logic [15:0] raw);
        light_valid <= 1'b1;
        light_guide <= raw;
        @(posedge ref_clk);
        light_valid <= 1'b0;
        light_guide <= ~raw;
        @(posedge ref_clk);
    endtask
    // log of two-byte brightness telegrams
    always @(posedge ref_clk) begin
        if (bright_send === 1'b1) begin
            sent <= sent + 1;
            last <= bright_value;
        end
    end
endmodule // pscl_bus_party

// ==== verif/pscl_core_asserts.sv ====
// pscl_core_asserts: bus wait state, lockout, hold-off, led, level and marker checks
// assumes it is bound into pscl_core and sees only the core's ports
`timescale 1ns/1ns
module pscl_core_asserts (
    // clock and reset
    input wire logic                     ref_clk,
    input wire logic                     resetn,
    // register bus
    input wire pscl_pkg::pscl_avreq_type av_req,
    input wire pscl_pkg::pscl_avrsp_type av_rsp,
    // events and outputs
    input wire logic                     bus_return,
    input wire logic                     interlock_valid,
    input wire logic                     interlock_value,
    input wire logic [8:0]               sector_level,
    input wire logic                     basic_low,
    input wire logic                     motion,
    input wire logic                     blue_led,
    input wire logic                     bright_send,
    input wire logic [15:0]              bright_value,
    input wire logic                     fb_enable
);
    logic [9:0]  ctrl_q;
    logic [8:0]  sens_q;
    logic [5:0]  lock_q;
    logic [11:0] dly_q;
    logic        hit;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!resetn);
    // shadow copies of the written setup words
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl_q <= 10'h000;
            sens_q <= 9'h124;
            lock_q <= 6'h03;
            dly_q  <= 12'h011;
        end else if (av_req.write) begin
            if (av_req.address == pscl_pkg::REG_CTRL) ctrl_q <= av_req.writedata[9:0];
            if (av_req.address == pscl_pkg::REG_SENS) sens_q <= av_req.writedata[8:0];
            if (av_req.address == pscl_pkg::REG_LOCK) lock_q <= av_req.writedata[5:0];
            if (av_req.address == pscl_pkg::REG_DELAY) dly_q <= av_req.writedata[11:0];
        end
    end
    // interlock telegram of the selected polarity
    assign hit = interlock_valid && (ctrl_q[6] || (ctrl_q[5] == interlock_value));
    sequence s_read_wait;
        av_rsp.waitrequest ##1 !av_rsp.waitrequest;
    endsequence
    sequence s_locked;
        ##2 !motion [*6];
    endsequence
    a_read_wait: assert property ($rose(av_req.read) |-> s_read_wait)
        else $error("read without exactly one wait state");
    a_unmapped_zero: assert property (av_req.read && !av_rsp.waitrequest
        && av_req.address > pscl_pkg::REG_EVENT |-> av_rsp.readdata == 32'h0)
        else $error("unmapped word read not zero");
    a_hold_off: assert property (
        bus_return && dly_q != 12'h000 |=> !bright_send [*8])
        else $error("send during bus return delay");
    a_lock_motion: assert property (hit && lock_q != 6'h00 |-> s_locked)
        else $error("motion during interlock lockout");
    a_blue_motion: assert property (blue_led |-> motion)
        else $error("blue led without motion");
    a_basic_follow: assert property (
        !$changed(ctrl_q) |-> basic_low == ctrl_q[3])
        else $error("basic sensitivity not as set");
    a_sector_follow: assert property (
        !ctrl_q[4] && !$changed(sens_q) && !$changed(ctrl_q) |-> sector_level == sens_q)
        else $error("sector level differs with adjuster off");
    a_pend_marker: assert property (
        bright_send && !fb_enable && ctrl_q[7]
        |-> ctrl_q[8] && bright_value == pscl_pkg::INVALID_BRIGHT)
        else $error("send while calibration pending");
endmodule // pscl_core_asserts

bind pscl_core pscl_core_asserts i_chk (.ref_clk, .resetn, .av_req, .av_rsp, .bus_return,
    .interlock_valid, .interlock_value, .sector_level, .basic_low, .motion, .blue_led,
    .bright_send, .bright_value, .fb_enable);
